//--- embi_map.vh
`ifndef EMBI_MAP_VH
`define EMBI_MAP_VH
// Bus widths
`define EMBI_ADDR_W 28
`define EMBI_DATA_W 32
`define EMBI_BE_W 4
`define EMBI_CS_W 5
// Region memory types
`define EMBI_MT_SRAM 2'h0
`define EMBI_MT_FPDRAM 2'h1
`define EMBI_MT_SDRAM 2'h2
// SDRAM command on column strobes {ras,cas,we}
`define EMBI_SD_ACT 3'h3
`define EMBI_SD_RD 3'h5
`define EMBI_SD_WR 3'h4
// Reset values
`define EMBI_CS_IDLE 5'h1F
`define EMBI_STRB_IDLE 4'hF
`define EMBI_BE_IDLE 4'hF
// Default wait cycles before internal termination
`define EMBI_WAIT_DEF 4'h2
`endif

//--- embi_bus.v
// Functional notes
// - All bus signals timed on bus clock
// - Drive 28-bit address each cycle
// - 32-bit data, device drives writes only
// - Four active-low byte lane enables driven
// - Acknowledge driven high before release
// - Error with done means burst end
// - Error alone flags error, ends burst
// - Error acknowledge never driven by the device
// - Direction high read, low write
// - Five selects; 1-4 double as RAS
// - Select zero is boot, no RAS
// - Column strobes: lanes or SDRAM command
// - Write strobe only on controller writes
// - Read strobe only on controller reads
// - Boot select with read or write gives boot strobes
// - Non-DRAM region keeps column strobes high
// - Select low marks memory cycle
`include "embi_map.vh"
`timescale 1ns/1ps
`default_nettype none
module embi_bus (
  input wire mclk_i,
  input wire rstn_i,
  input wire req_i,
  input wire req_read_i,
  input wire req_burst_i,
  input wire [27:0] req_addr_i,
  input wire [31:0] req_wdata_i,
  input wire [3:0] req_be_i,
  input wire [2:0] req_cs_i,
  input wire [1:0] req_mtype_i,
  input wire [3:0] req_wait_i,
  input wire req_ext_ack_i,
  output reg req_ready_o,
  output reg done_o,
  output reg err_o,
  output reg burst_end_o,
  output reg [31:0] rdata_o,
  input wire [27:0] addr_i,
  output reg [27:0] addr_o,
  output reg addr_oe_o,
  input wire [31:0] data_i,
  output reg [31:0] data_o,
  output reg data_oe_o,
  input wire [3:0] byte_lane_enable_n_i,
  output reg [3:0] byte_lane_enable_n_o,
  output reg byte_lane_enable_n_oe_o,
  input wire read_write_i,
  output reg read_write_o,
  output reg read_write_oe_o,
  input wire cycle_done_n_i,
  output reg cycle_done_n_o,
  output reg cycle_done_n_oe_o,
  input wire cycle_error_n_i,
  output reg cycle_error_n_o,
  output reg cycle_error_n_oe_o,
  output reg boot_select_n_o,
  output reg region_select_1_n_o,
  output reg region_select_2_n_o,
  output reg region_select_3_n_o,
  output reg region_select_4_n_o,
  output reg column_strobe_0_n_o,
  output reg column_strobe_1_n_o,
  output reg column_strobe_2_n_o,
  output reg column_strobe_3_n_o,
  output reg write_strobe_n_o,
  output reg read_strobe_n_o,
  output reg boot_read_strobe_n_o,
  output reg boot_write_strobe_n_o
);
  localparam ST_IDLE = 2'h0;
  localparam ST_ACT = 2'h1;
  localparam ST_RLS = 2'h2;

  reg [1:0] state_r;
  reg rd_r;
  reg brst_r;
  reg ext_r;
  reg [1:0] mt_r;
  reg [2:0] cs_r;
  reg [3:0] be_r;
  reg [3:0] wait_r;
  reg [4:0] csn_nxt;
  reg [3:0] cas_nxt;
  wire ext_done;
  wire ext_err;
  wire int_done;
  wire hit_cs;

  // Acknowledges sampled on the clock edge only
  assign ext_done = ext_r & ~cycle_done_n_i;
  assign ext_err = ext_r & ~cycle_error_n_i;
  assign int_done = ~ext_r & (wait_r == 4'h0);
  assign hit_cs = (cs_r < 3'h5);

  // Chip select and column strobe patterns for the active region
  always @* begin
    csn_nxt = `EMBI_CS_IDLE;
    cas_nxt = `EMBI_STRB_IDLE;
    if (hit_cs) begin
      csn_nxt[cs_r] = 1'b0;
    end
    if (mt_r == `EMBI_MT_FPDRAM && cs_r != 3'h0 && hit_cs) begin
      cas_nxt = be_r;
    end else if (mt_r == `EMBI_MT_SDRAM && cs_r != 3'h0 && hit_cs) begin
      cas_nxt[3:1] = rd_r ? `EMBI_SD_RD : `EMBI_SD_WR;
      cas_nxt[0] = ~brst_r;
    end
  end

  // Cycle state machine, everything on mclk_i which is the bus clock
  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r <= ST_IDLE;
      rd_r <= 1'b1;
      brst_r <= 1'b0;
      ext_r <= 1'b0;
      mt_r <= `EMBI_MT_SRAM;
      cs_r <= 3'h7;
      be_r <= `EMBI_BE_IDLE;
      wait_r <= `EMBI_WAIT_DEF;
      req_ready_o <= 1'b0;
      done_o <= 1'b0;
      err_o <= 1'b0;
      burst_end_o <= 1'b0;
      rdata_o <= 32'h00000000;
      addr_o <= 28'h0000000;
      addr_oe_o <= 1'b0;
      data_o <= 32'h00000000;
      data_oe_o <= 1'b0;
      byte_lane_enable_n_o <= `EMBI_BE_IDLE;
      byte_lane_enable_n_oe_o <= 1'b0;
      read_write_o <= 1'b1;
      read_write_oe_o <= 1'b0;
      cycle_done_n_o <= 1'b1;
      cycle_done_n_oe_o <= 1'b0;
      cycle_error_n_o <= 1'b1;
      cycle_error_n_oe_o <= 1'b0;
      {region_select_4_n_o, region_select_3_n_o, region_select_2_n_o,
        region_select_1_n_o, boot_select_n_o} <= `EMBI_CS_IDLE;
      {column_strobe_3_n_o, column_strobe_2_n_o, column_strobe_1_n_o,
        column_strobe_0_n_o} <= `EMBI_STRB_IDLE;
      write_strobe_n_o <= 1'b1;
      read_strobe_n_o <= 1'b1;
      boot_read_strobe_n_o <= 1'b1;
      boot_write_strobe_n_o <= 1'b1;
    end else begin
      done_o <= 1'b0;
      err_o <= 1'b0;
      burst_end_o <= 1'b0;
      req_ready_o <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          req_ready_o <= 1'b1;
          if (req_i && req_ready_o) begin
            req_ready_o <= 1'b0;
            rd_r <= req_read_i;
            brst_r <= req_burst_i;
            ext_r <= req_ext_ack_i;
            mt_r <= req_mtype_i;
            cs_r <= req_cs_i;
            be_r <= req_be_i;
            wait_r <= req_wait_i;
            addr_o <= req_addr_i;
            addr_oe_o <= 1'b1;
            data_o <= req_wdata_i;
            data_oe_o <= ~req_read_i;
            byte_lane_enable_n_o <= req_be_i;
            byte_lane_enable_n_oe_o <= 1'b1;
            read_write_o <= req_read_i;
            read_write_oe_o <= 1'b1;
            state_r <= ST_ACT;
          end
        end
        ST_ACT: begin
          {region_select_4_n_o, region_select_3_n_o, region_select_2_n_o,
            region_select_1_n_o, boot_select_n_o} <= csn_nxt;
          {column_strobe_3_n_o, column_strobe_2_n_o, column_strobe_1_n_o,
            column_strobe_0_n_o} <= cas_nxt;
          write_strobe_n_o <= ~(hit_cs & ~rd_r);
          read_strobe_n_o <= ~(hit_cs & rd_r);
          // Boot strobes are active-low AND of select and strobe
          boot_read_strobe_n_o <= ~(cs_r == 3'h0 & rd_r);
          boot_write_strobe_n_o <= ~(cs_r == 3'h0 & ~rd_r);
          if (!int_done && !ext_r) begin
            wait_r <= wait_r - 4'h1;
          end
          if (ext_done || ext_err || int_done) begin
            if (int_done) begin
              cycle_done_n_o <= 1'b0;
              cycle_done_n_oe_o <= 1'b1;
            end
            // Error alone is a fault; with done it just ends the burst
            err_o <= ext_err & ~ext_done;
            burst_end_o <= ext_err | ~brst_r;
            done_o <= 1'b1;
            if (rd_r) begin
              rdata_o <= data_i;
            end
            state_r <= ST_RLS;
          end
        end
        ST_RLS: begin
          // Drive done acknowledge high for one cycle if it was driven low, then release both
          if (cycle_done_n_oe_o && !cycle_done_n_o) begin
            cycle_done_n_o <= 1'b1;
          end else begin
            cycle_done_n_oe_o <= 1'b0;
            cycle_error_n_oe_o <= 1'b0;
            cycle_error_n_o <= 1'b1;
            state_r <= ST_IDLE;
          end
          {region_select_4_n_o, region_select_3_n_o, region_select_2_n_o,
            region_select_1_n_o, boot_select_n_o} <= `EMBI_CS_IDLE;
          {column_strobe_3_n_o, column_strobe_2_n_o, column_strobe_1_n_o,
            column_strobe_0_n_o} <= `EMBI_STRB_IDLE;
          write_strobe_n_o <= 1'b1;
          read_strobe_n_o <= 1'b1;
          boot_read_strobe_n_o <= 1'b1;
          boot_write_strobe_n_o <= 1'b1;
          addr_oe_o <= 1'b0;
          data_oe_o <= 1'b0;
          byte_lane_enable_n_oe_o <= 1'b0;
          read_write_oe_o <= 1'b0;
          read_write_o <= 1'b1;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // embi_bus
`default_nettype wire

//--- embi_bus_props.sv
`timescale 1ns/1ps
`default_nettype none
module embi_bus_props (
  input wire logic mclk_i, rstn_i, done_o, err_o, burst_end_o,
  input wire logic read_write_o, read_write_oe_o, write_strobe_n_o,
  input wire logic read_strobe_n_o, boot_select_n_o, boot_read_strobe_n_o,
  input wire logic boot_write_strobe_n_o, cycle_done_n_o,
  input wire logic cycle_done_n_oe_o, cycle_done_n_i, cycle_error_n_i
);
  // Bus clock checks, off in reset
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  wr_strobe_a: assert property (
    !write_strobe_n_o |-> read_write_oe_o && !read_write_o) else $error("we");
  rd_strobe_a: assert property (
    !read_strobe_n_o |-> read_write_oe_o && read_write_o) else $error("oe");
  boot_read_a: assert property (
    boot_select_n_o == read_strobe_n_o |->
    boot_read_strobe_n_o == boot_select_n_o) else $error("boot read");
  boot_write_a: assert property (
    boot_select_n_o == write_strobe_n_o |->
    boot_write_strobe_n_o == boot_select_n_o) else $error("boot write");
  ack_release_a: assert property (
    $fell(cycle_done_n_oe_o) |-> $past(cycle_done_n_o)) else $error("ack");
  dir_hold_a: assert property (
    read_write_oe_o [*2] |-> $stable(read_write_o)) else $error("dir");
  err_alone_a: assert property (
    err_o |-> burst_end_o && $past(cycle_done_n_i && !cycle_error_n_i))
    else $error("error end");
  burst_end_a: assert property (
    done_o && $past(!cycle_done_n_i && !cycle_error_n_i) |->
    !err_o && burst_end_o) else $error("burst end");
endmodule // embi_bus_props
bind embi_bus embi_bus_props embi_bus_props_inst (.*);
`default_nettype wire

//--- embi_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module embi_mem_model (
  input wire logic mclk_i, sel_n_i, oe_n_i, we_n_i, ack_en_i,
  input wire logic [1:0] mode_i,
  input wire logic [3:0] be_n_i,
  input wire logic [31:0] wdata_i,
  output logic [31:0] rdata_o,
  output logic done_n_o, err_n_o, ack_oe_o
);
  logic [31:0] mem_r = 32'h0, last_r = 32'h0;
  logic [2:0] st_r = 3'h0;
  // Acks low one cycle, high one more, then released to pull-up
  assign ack_oe_o = ack_en_i && (st_r == 3'h5 || st_r == 3'h6);
  assign done_n_o = !(st_r == 3'h5 && mode_i != 2'h1);
  assign err_n_o = !(st_r == 3'h5 && mode_i != 2'h0);
  // Released data shows the inverse of the last word
  assign rdata_o = (!sel_n_i && !oe_n_i) ? mem_r : ~last_r;
  // Wait count while selected, lanes stored on write
  always @(posedge mclk_i) begin
    st_r <= sel_n_i ? 3'h0 : st_r + 3'(st_r != 3'h7);
    if (!sel_n_i && !oe_n_i) last_r <= mem_r;
    for (int i = 0; i < 4; i++)
      if (!sel_n_i && !we_n_i && !be_n_i[i])
        mem_r[8*i +: 8] <= wdata_i[8*i +: 8];
  end
endmodule // embi_mem_model
`default_nettype wire

//--- embi_bus_tb.sv
`timescale 1ns/1ps
`default_nettype none
module embi_bus_tb;
  typedef struct packed {
    logic rd; logic [2:0] cs; logic [1:0] mt; logic ext; logic [1:0] md;
    logic [3:0] be; logic [31:0] d; logic er;
  } embi_row_t;
  embi_row_t rows [5] = '{
    '{1'h0, 3'h1, 2'h0, 1'h1, 2'h0, 4'h0, 32'h12345678, 1'h0},
    '{1'h1, 3'h3, 2'h2, 1'h1, 2'h2, 4'h0, 32'h12345678, 1'h0},
    '{1'h0, 3'h2, 2'h1, 1'h0, 2'h0, 4'hC, 32'hAAAA5555, 1'h0},
    '{1'h1, 3'h0, 2'h1, 1'h0, 2'h0, 4'h0, 32'h12345555, 1'h0},
    '{1'h1, 3'h4, 2'h0, 1'h1, 2'h1, 4'h0, 32'h0, 1'h1}};
  logic mclk_i = 1'h0, rstn_i = 1'h0, req_i = 1'h0, req_read_i = 1'h0;
  logic req_burst_i = 1'h0, req_ext_ack_i = 1'h0;
  logic [1:0] req_mtype_i = 2'h0, md = 2'h0;
  logic [2:0] req_cs_i = 3'h0;
  logic [3:0] req_be_i = 4'h0, req_wait_i = 4'h2;
  logic [27:0] req_addr_i = 28'h10;
  logic [31:0] req_wdata_i = 32'h0;
  int errors = 0, compares = 0;
  wire req_ready_o, done_o, err_o, burst_end_o, addr_oe_o, data_oe_o, m_dn;
  wire byte_lane_enable_n_oe_o, read_write_o, read_write_oe_o, read_write_i;
  wire cycle_done_n_o, cycle_done_n_oe_o, cycle_done_n_i, cycle_error_n_o;
  wire cycle_error_n_oe_o, cycle_error_n_i, boot_select_n_o, m_en, m_oe;
  wire region_select_1_n_o, region_select_2_n_o, region_select_3_n_o;
  wire region_select_4_n_o, column_strobe_0_n_o, column_strobe_1_n_o;
  wire column_strobe_2_n_o, column_strobe_3_n_o, write_strobe_n_o;
  wire read_strobe_n_o, boot_read_strobe_n_o, boot_write_strobe_n_o;
  wire [3:0] byte_lane_enable_n_o, byte_lane_enable_n_i;
  wire [27:0] addr_o, addr_i;
  wire [31:0] rdata_o, data_o, data_i, m_rd;
  wire [4:0] sels = {region_select_4_n_o, region_select_3_n_o,
    region_select_2_n_o, region_select_1_n_o, boot_select_n_o};
  wire [3:0] cols = {column_strobe_3_n_o, column_strobe_2_n_o,
    column_strobe_1_n_o, column_strobe_0_n_o};
  // Wire levels: driver if any, else pull-up or inverse of last value
  assign addr_i = addr_oe_o ? addr_o : 28'hFFFFFFF;
  assign data_i = data_oe_o ? data_o : m_rd;
  assign byte_lane_enable_n_i = byte_lane_enable_n_o ^ {4{!byte_lane_enable_n_oe_o}};
  assign read_write_i = read_write_o ^ !read_write_oe_o;
  assign cycle_done_n_i = cycle_done_n_oe_o ? cycle_done_n_o : !m_oe | m_dn;
  assign cycle_error_n_i = cycle_error_n_oe_o ? cycle_error_n_o : !m_oe | m_en;
  embi_bus embi_bus_inst (.*);
  embi_mem_model embi_mem_model_inst (.mclk_i, .sel_n_i(&sels),
    .oe_n_i(read_strobe_n_o), .we_n_i(write_strobe_n_o),
    .ack_en_i(req_ext_ack_i), .mode_i(md), .be_n_i(byte_lane_enable_n_i),
    .wdata_i(data_i), .rdata_o(m_rd), .done_n_o(m_dn), .err_n_o(m_en),
    .ack_oe_o(m_oe));
  always #5 mclk_i = ~mclk_i;
  task chk(input logic [31:0] g, e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task end_sim;
    $display("Compares %0d, errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // One bus cycle from a row, watching the pins while selected
  task run(input embi_row_t r);
    int n;
    logic seen, rw;
    logic [4:0] sel;
    logic [3:0] ec;
    logic [27:0] ad;
    logic [4:0] bd;
    ec = r.mt == 2'h2 ? {3'h4 | r.rd, 1'h1} :
      (r.mt == 2'h1 && r.cs != 3'h0) ? r.be : 4'hF;
    @(posedge mclk_i);
    {req_read_i, req_cs_i, req_mtype_i, req_ext_ack_i, md, req_be_i} <= r[45:33];
    req_wdata_i <= r.d;
    req_i <= 1'h1;
    n = 0;
    seen = 1'h0;
    do @(negedge mclk_i); while (req_ready_o !== 1'h1 && ++n < 50);
    @(posedge mclk_i);
    req_i <= 1'h0;
    do begin
      @(negedge mclk_i);
      if (sels !== 5'h1F) begin
        sel = sels;
        rw = read_write_o;
        ad = addr_o;
        bd = {byte_lane_enable_n_o, data_oe_o};
        seen |= cols === ec;
      end
    end while (done_o !== 1'h1 && err_o !== 1'h1 && ++n < 99);
    chk(32'({err_o, burst_end_o}), 32'({r.er, 1'h1}));
    if (r.rd && !r.er) chk(rdata_o, r.d);
    chk(32'({sel, rw, seen}), 32'({~(5'h1 << r.cs), r.rd, 1'h1}));
    chk(32'(ad), 32'h10);
    chk(32'(bd), 32'({r.be, !r.rd}));
    $display("Cycle on select %0d done", r.cs);
  endtask
  // Rows first, then a reset landing inside an external cycle
  initial begin
    repeat (10) @(posedge mclk_i);
    rstn_i <= 1'h1;
    foreach (rows[i]) run(rows[i]);
    @(posedge mclk_i);
    req_i <= 1'h1;
    repeat (4) @(posedge mclk_i);
    rstn_i <= 1'h0;
    req_i <= 1'h0;
    @(negedge mclk_i);
    chk(32'({sels, cols, req_ready_o}), 32'h3FE);
    @(posedge mclk_i);
    rstn_i <= 1'h1;
    repeat (2) @(negedge mclk_i);
    chk(32'(req_ready_o), 32'h1);
    $display("Mid-cycle reset done");
    end_sim;
  end
  // Watchdog
  initial begin
    #100000;
    errors++;
    end_sim;
  end
endmodule // embi_bus_tb
`default_nettype wire
